/* File: lsr_pkg.sv */
// Shared constants, types and scaling helper for the light level readout
package lsr_pkg;

   // ----------------------------------------------------------------------
   // Register map and reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] LSR_ADDR_S2_DARK_HYS = 8'h3A;
   localparam logic [7:0] LSR_ADDR_S1_RES_HI   = 8'h3B;
   localparam logic [7:0] LSR_ADDR_S1_RES_LO   = 8'h3C;
   localparam logic [7:0] LSR_ADDR_S2_RES_HI   = 8'h3D;
   localparam logic [7:0] LSR_ADDR_S2_RES_LO   = 8'h3E;
   localparam logic [7:0] LSR_RST_DARK_HYS     = 8'h00;
   localparam logic [7:0] LSR_UNMAPPED_DATA    = 8'h00;

   // ----------------------------------------------------------------------
   // Converter scaling: 8000 codes span 1000 uA, one code is 0.125 uA
   // ----------------------------------------------------------------------
   localparam int LSR_RES_W          = 13;
   localparam int LSR_FULL_SCALE_UA  = 1000;
   localparam int LSR_FULL_SCALE_CNT = 8000;
   localparam int LSR_HI_BITS        = LSR_RES_W - 8;
   // Dark fields step 0.5 uA = 4 codes, office fields step 4 uA = 32 codes
   localparam logic [2:0] LSR_DARK_SHIFT   = 3'h2;
   localparam logic [2:0] LSR_OFFICE_SHIFT = 3'h5;
   // Full dark hysteresis code 0xFF spans 127.5 uA, i.e. 1020 codes
   localparam int LSR_DARK_SPAN_CNT = 255 * 4;
   localparam int LSR_CMP_W         = 15;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      LSR_OUTDOOR,
      LSR_OFFICE,
      LSR_DARK
   } lsr_level_t;

   typedef struct packed {
      logic                 valid;
      logic [LSR_RES_W-1:0] code;
   } lsr_sample_t;

   typedef struct packed {
      logic [7:0] office_trip;
      logic [7:0] office_hys;
      logic [7:0] dark_trip;
      logic [7:0] dark_hys;
   } lsr_levels_t;

   typedef struct packed {
      lsr_level_t level;
      logic       office;
      logic       dark;
      logic       change;
   } lsr_track_t;

   typedef struct packed {
      logic [7:0]           dark_hys2;
      logic [LSR_RES_W-1:0] res1;
      logic [LSR_RES_W-1:0] res2;
      logic [7:0]           rdata;
      logic                 rvalid;
      logic                 irq;
   } lsr_top_t;

   // Level field (optionally plus hysteresis) in converter codes
   function automatic logic [LSR_CMP_W-1:0] lsr_to_codes(
      input logic [7:0] trip,
      input logic [7:0] hys,
      input logic [2:0] shift
   );
      logic [8:0] sum;
      sum = {1'b0, trip} + {1'b0, hys};
      return LSR_CMP_W'(sum) << shift;
   endfunction

endpackage

/* File: lsr_level_track.sv */
// Per-sensor light level tracker with trip and hysteresis thresholds
`timescale 1ns/10ps
`default_nettype none

module lsr_level_track
   import lsr_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   input  wire lsr_sample_t i_sample,
   input  wire lsr_levels_t i_levels,
   output logic             o_office_level_flag,
   output logic             o_dark_level_flag,
   output logic             o_level_change
);

   lsr_track_t             st;
   lsr_track_t             next_st;
   logic [LSR_CMP_W-1:0]   dark_in;
   logic [LSR_CMP_W-1:0]   dark_out;
   logic [LSR_CMP_W-1:0]   office_in;
   logic [LSR_CMP_W-1:0]   office_out;
   logic [LSR_CMP_W-1:0]   code;

   // ----------------------------------------------------------------------
   // Thresholds in converter codes
   // ----------------------------------------------------------------------
   always_comb begin
      code       = LSR_CMP_W'(i_sample.code);
      dark_in    = lsr_to_codes(i_levels.dark_trip, 8'h00, LSR_DARK_SHIFT);
      dark_out   = lsr_to_codes(i_levels.dark_trip, i_levels.dark_hys,
                                LSR_DARK_SHIFT); // R10
      office_in  = lsr_to_codes(i_levels.office_trip, 8'h00,
                                LSR_OFFICE_SHIFT); // R7
      office_out = lsr_to_codes(i_levels.office_trip, i_levels.office_hys,
                                LSR_OFFICE_SHIFT);
   end

   // ----------------------------------------------------------------------
   // Level state machine, advanced only on a new conversion
   // ----------------------------------------------------------------------
   always_comb begin
      next_st        = st;
      next_st.change = 1'b0;
      if (i_sample.valid) begin
         unique case (st.level)
            LSR_DARK: begin
               if (code > dark_out) begin
                  next_st.level  = LSR_OFFICE; // R1
                  next_st.dark   = 1'b0;
                  next_st.change = 1'b1;
               end
            end
            LSR_OFFICE: begin
               if (code < dark_in) begin
                  next_st.level  = LSR_DARK; // R8
                  next_st.dark   = 1'b1;
                  next_st.change = 1'b1;
               end else if (code > office_out) begin
                  next_st.level  = LSR_OUTDOOR; // R9
                  next_st.office = 1'b0;
                  next_st.change = 1'b1;
               end
            end
            LSR_OUTDOOR: begin
               // A deep drop passes office on its way to dark
               if (code < dark_in) begin
                  next_st.level  = LSR_DARK; // R8
                  next_st.dark   = 1'b1;
                  next_st.office = 1'b1;
                  next_st.change = 1'b1;
               end else if (code < office_in) begin
                  next_st.level  = LSR_OFFICE; // R9
                  next_st.office = 1'b1;
                  next_st.change = 1'b1;
               end
            end
            default: begin
               next_st.level = LSR_OUTDOOR;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '{level: LSR_OUTDOOR, office: 1'b0, dark: 1'b0,
                 change: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign o_office_level_flag = st.office;
   assign o_dark_level_flag   = st.dark;
   assign o_level_change      = st.change;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_dark_entry: assert property ( // R8
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_sample.valid && code < dark_in |=> st.dark && st.level == LSR_DARK)
      else $error("dark level not entered below dark trip");

   a_dark_exit: assert property ( // R1
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.level == LSR_DARK && i_sample.valid && code > dark_out
      |=> !st.dark && st.office && st.level == LSR_OFFICE && st.change)
      else $error("dark level not left above trip plus hysteresis");

   a_office_entry: assert property ( // R9
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.level == LSR_OUTDOOR && i_sample.valid && code < office_in
      |=> st.office && st.change)
      else $error("office level not entered below office trip");

   a_office_exit: assert property ( // R9
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.level == LSR_OFFICE && i_sample.valid && code >= dark_in &&
      code > office_out |=> !st.office && st.level == LSR_OUTDOOR)
      else $error("office level not left above trip plus hysteresis");

   a_hold_idle: assert property ( // R6
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !i_sample.valid |=> !st.change && $stable(st.level))
      else $error("level moved without a conversion");

   c_enter_dark: cover property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.level == LSR_OFFICE ##1 st.level == LSR_DARK);

   c_leave_dark: cover property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      st.level == LSR_DARK ##1 st.level == LSR_OFFICE);

endmodule

`default_nettype wire

/* File: lsr_light_readout.sv */
// Light sensor level readout: result registers, hysteresis, level flags
`timescale 1ns/10ps
`default_nettype none

// Operation
// R1: Sensor 2 leaves dark above trip plus hysteresis
// R2: Dark hysteresis spans 0 to 127.5 uA
// R3: Result bits 12..8 in high byte, top zero
// R4: Result bits 7..0 in low byte, read-only
// R5: Sensor 2 result uses same two-byte layout
// R6: Level change raises an alert to host
// R7: One converter code is 0.125 uA
// R8: Below dark trip enters dark, sets flag
// R9: Office flag set below trip, cleared above
// R10: Dark hysteresis step is 0.5 uA
module lsr_light_readout
   import lsr_pkg::*;
#(
   parameter int RES_W = LSR_RES_W
)(
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_wdata,
   output logic [7:0]       o_reg_rdata,
   output logic             o_reg_rvalid,
   input  wire lsr_sample_t i_s1_sample,
   input  wire lsr_sample_t i_s2_sample,
   input  wire lsr_levels_t i_s1_levels,
   input  wire logic [7:0]  i_s2_office_trip,
   input  wire logic [7:0]  i_s2_office_hys,
   input  wire logic [7:0]  i_s2_dark_trip,
   output logic             o_s1_office_level_flag,
   output logic             o_s1_dark_level_flag,
   output logic             o_s2_office_level_flag,
   output logic             o_s2_dark_level_flag,
   output logic             o_level_irq
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (RES_W != LSR_RES_W) begin : g_bad_width
      $error("result width must match the two-byte layout");
   end
   if (LSR_FULL_SCALE_CNT != LSR_FULL_SCALE_UA * 8) begin : g_bad_scale
      $error("converter scale must be 0.125 uA per code");
   end

   lsr_top_t    st;
   lsr_top_t    next_st;
   lsr_levels_t s2_levels;
   logic        s1_change;
   logic        s2_change;

   // Sensor 2 dark hysteresis comes from the local register
   always_comb begin
      s2_levels.office_trip = i_s2_office_trip;
      s2_levels.office_hys  = i_s2_office_hys;
      s2_levels.dark_trip   = i_s2_dark_trip;
      s2_levels.dark_hys    = st.dark_hys2; // R1
   end

   // ----------------------------------------------------------------------
   // Per-sensor level trackers
   // ----------------------------------------------------------------------
   lsr_level_track u_track_s1 (
      .i_ref_clk           (i_ref_clk),
      .i_arst_n            (i_arst_n),
      .i_sample            (i_s1_sample),
      .i_levels            (i_s1_levels),
      .o_office_level_flag (o_s1_office_level_flag),
      .o_dark_level_flag   (o_s1_dark_level_flag),
      .o_level_change      (s1_change)
   );

   lsr_level_track u_track_s2 (
      .i_ref_clk           (i_ref_clk),
      .i_arst_n            (i_arst_n),
      .i_sample            (i_s2_sample),
      .i_levels            (s2_levels),
      .o_office_level_flag (o_s2_office_level_flag),
      .o_dark_level_flag   (o_s2_dark_level_flag),
      .o_level_change      (s2_change)
   );

   // ----------------------------------------------------------------------
   // Register file, result capture and alert
   // ----------------------------------------------------------------------
   always_comb begin
      next_st        = st;
      next_st.rvalid = i_reg_rd;
      // Any change on either sensor alerts the host one cycle later
      next_st.irq    = s1_change | s2_change; // R6
      // Only the hysteresis byte is writable; all 8 bits span 127.5 uA
      if (i_reg_wr && i_reg_addr == LSR_ADDR_S2_DARK_HYS) begin
         next_st.dark_hys2 = i_reg_wdata; // R2
      end
      // Results keep the newest conversion; writes cannot reach them
      if (i_s1_sample.valid) begin
         next_st.res1 = i_s1_sample.code; // R4
      end
      if (i_s2_sample.valid) begin
         next_st.res2 = i_s2_sample.code; // R5
      end
      // Read returns the stored value, before this cycle's capture
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            LSR_ADDR_S2_DARK_HYS: next_st.rdata = st.dark_hys2;
            LSR_ADDR_S1_RES_HI:
               next_st.rdata = {3'h0, st.res1[RES_W-1:8]}; // R3
            LSR_ADDR_S1_RES_LO: next_st.rdata = st.res1[7:0]; // R4
            LSR_ADDR_S2_RES_HI:
               next_st.rdata = {3'h0, st.res2[RES_W-1:8]}; // R5
            LSR_ADDR_S2_RES_LO: next_st.rdata = st.res2[7:0]; // R5
            default:            next_st.rdata = LSR_UNMAPPED_DATA;
         endcase
      end
   end

   // State register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '{dark_hys2: LSR_RST_DARK_HYS, res1: '0, res2: '0,
                 rdata: 8'h00, rvalid: 1'b0, irq: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign o_reg_rdata  = st.rdata;
   assign o_reg_rvalid = st.rvalid;
   assign o_level_irq  = st.irq;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_hys_write: assert property ( // R2
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_reg_wr && i_reg_addr == LSR_ADDR_S2_DARK_HYS
      |=> st.dark_hys2 == $past(i_reg_wdata))
      else $error("dark hysteresis write not stored");

   a_hys_readback: assert property ( // R10
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_reg_wr && i_reg_addr == LSR_ADDR_S2_DARK_HYS ##1
      !i_reg_wr ##1
      i_reg_rd && i_reg_addr == LSR_ADDR_S2_DARK_HYS && !i_reg_wr
      |=> o_reg_rdata == $past(i_reg_wdata, 3) && o_reg_rvalid)
      else $error("dark hysteresis readback wrong");

   a_high_byte: assert property ( // R3
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_s1_sample.valid ##1
      i_reg_rd && i_reg_addr == LSR_ADDR_S1_RES_HI && !i_s1_sample.valid
      |=> o_reg_rdata == {3'h0, $past(i_s1_sample.code[12:8], 2)})
      else $error("sensor 1 high byte wrong");

   a_low_byte: assert property ( // R4
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_s1_sample.valid ##1
      i_reg_rd && i_reg_addr == LSR_ADDR_S1_RES_LO
      |=> o_reg_rdata == $past(i_s1_sample.code[7:0], 2))
      else $error("sensor 1 low byte wrong");

   a_s2_bytes: assert property ( // R5
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_s2_sample.valid ##1
      i_reg_rd && i_reg_addr == LSR_ADDR_S2_RES_HI
      |=> o_reg_rdata[7:5] == 3'h0 &&
          o_reg_rdata[4:0] == $past(i_s2_sample.code[12:8], 2))
      else $error("sensor 2 high byte wrong");

   a_irq_follow: assert property ( // R6
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (s1_change || s2_change) |=> o_level_irq)
      else $error("level change did not alert host");

   a_unmapped: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_reg_rd && (i_reg_addr < LSR_ADDR_S2_DARK_HYS ||
                   i_reg_addr > LSR_ADDR_S2_RES_LO)
      |=> o_reg_rdata == LSR_UNMAPPED_DATA)
      else $error("unmapped read not zero");

   a_read_answer: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered in the next cycle");

   a_no_answer: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !i_reg_rd |=> !o_reg_rvalid)
      else $error("read answer without a read strobe");

   a_s2_low_byte: assert property ( // R5
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_s2_sample.valid ##1
      i_reg_rd && i_reg_addr == LSR_ADDR_S2_RES_LO
      |=> o_reg_rdata == $past(i_s2_sample.code[7:0], 2))
      else $error("sensor 2 low byte wrong");

   a_result_ro: assert property ( // R4
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_reg_wr && !i_s1_sample.valid && !i_s2_sample.valid
      |=> $stable(st.res1) && $stable(st.res2))
      else $error("write reached a read-only result");

   a_hys_hold: assert property ( // R2
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !(i_reg_wr && i_reg_addr == LSR_ADDR_S2_DARK_HYS)
      |=> $stable(st.dark_hys2))
      else $error("dark hysteresis moved without a write");

   a_irq_quiet: assert property ( // R6
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !s1_change && !s2_change |=> !o_level_irq)
      else $error("alert raised without a level change");

   c_irq: cover property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_level_irq);

   c_s2_dark: cover property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_s2_dark_level_flag ##[1:50] !o_s2_dark_level_flag);

   c_result_read: cover property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_reg_rd && i_reg_addr == LSR_ADDR_S2_RES_LO);

endmodule

`default_nettype wire

/* File: lsr_host_model.sv */
// Host-side register master model that also counts level alerts
`timescale 1ns/10ps
`default_nettype none

module lsr_host_model (
   input  wire logic  i_ref_clk,
   input  wire logic  i_level_irq,
   output logic [7:0] o_reg_addr,
   output logic       o_reg_wr,
   output logic       o_reg_rd,
   output logic [7:0] o_reg_wdata,
   output logic [15:0] o_irq_count
);

   // ----------------------------------------------------------------------
   // Idle bus state at time zero
   // ----------------------------------------------------------------------
   initial begin
      o_reg_addr  = 8'h00;
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_wdata = 8'h00;
      o_irq_count = 16'h0000;
   end

   // Count alert pulses away from the launching edge to avoid a race
   always @(negedge i_ref_clk) begin
      if (i_level_irq === 1'b1) begin
         o_irq_count <= o_irq_count + 16'h0001;
      end
   end

   // One strobe cycle; the port has no ready, so it is taken at one edge.
   // Released lines show the inverse so a stale value is never reused.
   task automatic access(input logic wr, input logic [7:0] addr,
                         input logic [7:0] data);
      @(posedge i_ref_clk);
      #1;
      o_reg_addr  = addr;
      o_reg_wdata = data;
      o_reg_wr    = wr;
      o_reg_rd    = !wr;
      @(posedge i_ref_clk);
      #1;
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = ~addr;
      o_reg_wdata = ~data;
   endtask

endmodule

`default_nettype wire

/* File: lsr_light_readout_tb.sv */
// Self-checking testbench for the light sensor level readout
`timescale 1ns/10ps
`default_nettype none

module lsr_light_readout_tb;
   import lsr_pkg::*;

   logic        i_ref_clk;
   logic        i_arst_n;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        reg_wr;
   logic        reg_rd;
   logic        reg_rvalid;
   lsr_sample_t s1_sample;
   lsr_sample_t s2_sample;
   lsr_levels_t s1_levels;
   logic [7:0]  s2_office_trip;
   logic [7:0]  s2_office_hys;
   logic [7:0]  s2_dark_trip;
   logic        s1_off;
   logic        s1_dark;
   logic        s2_off;
   logic        s2_dark;
   logic        level_irq;
   logic [15:0] irq_count;
   logic [31:0] seed;
   logic [7:0]  exp_q[$];
   int          bad_count;
   int          n_checks;
   int          t;
   int          h;
   int          o;
   int          oh;

   lsr_light_readout #(.RES_W(LSR_RES_W)) lsr_light_readout_inst (
      .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
      .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
      .o_reg_rvalid(reg_rvalid), .i_s1_sample(s1_sample),
      .i_s2_sample(s2_sample), .i_s1_levels(s1_levels),
      .i_s2_office_trip(s2_office_trip), .i_s2_office_hys(s2_office_hys),
      .i_s2_dark_trip(s2_dark_trip), .o_s1_office_level_flag(s1_off),
      .o_s1_dark_level_flag(s1_dark), .o_s2_office_level_flag(s2_off),
      .o_s2_dark_level_flag(s2_dark), .o_level_irq(level_irq));

   lsr_host_model lsr_host_model_inst (
      .i_ref_clk(i_ref_clk), .i_level_irq(level_irq),
      .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
      .o_reg_wdata(reg_wdata), .o_irq_count(irq_count));

   // ----------------------------------------------------------------------
   // Clock, random source and reporting
   // ----------------------------------------------------------------------
   initial i_ref_clk = 1'b0;
   always #5 i_ref_clk = ~i_ref_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Read data settles before the falling edge; oldest note is compared
   always @(negedge i_ref_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(8'h01, 8'h00, "read answer without request");
         end else begin
            check(reg_rdata, exp_q.pop_front(), "read data");
         end
      end
   end

   // ----------------------------------------------------------------------
   // Stimulus helpers
   // ----------------------------------------------------------------------
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      exp_q.push_back(exp);
      lsr_host_model_inst.access(1'b0, addr, 8'h00);
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      lsr_host_model_inst.access(1'b1, addr, data);
   endtask

   // One conversion, then flags, alert count and both result bytes
   task automatic step(input int sn, input int code, input logic eo,
                       input logic ed, input int di);
      logic [15:0] c0;
      logic [12:0] c;
      c  = 13'(code);
      c0 = irq_count;
      @(posedge i_ref_clk);
      #1;
      if (sn == 1) s1_sample = '{1'b1, c};
      else s2_sample = '{1'b1, c};
      @(posedge i_ref_clk);
      #1;
      s1_sample = '{1'b0, ~s1_sample.code};
      s2_sample = '{1'b0, ~s2_sample.code};
      repeat (3) @(posedge i_ref_clk);
      #1;
      if (sn == 1) check({6'h00, s1_off, s1_dark}, {6'h00, eo, ed}, "flags");
      else check({6'h00, s2_off, s2_dark}, {6'h00, eo, ed}, "flags");
      check(8'(irq_count - c0), 8'(di), "alert count");
      rd(sn == 1 ? LSR_ADDR_S1_RES_HI : LSR_ADDR_S2_RES_HI,
         {3'h0, c[12:8]});
      rd(sn == 1 ? LSR_ADDR_S1_RES_LO : LSR_ADDR_S2_RES_LO, c[7:0]);
   endtask

   // Conversion followed at once by a read of one result byte
   task automatic fresh(input int sn, input logic [12:0] c, input logic hi);
      logic [7:0] a;
      logic [7:0] e;
      a = (sn == 1) ? (hi ? LSR_ADDR_S1_RES_HI : LSR_ADDR_S1_RES_LO)
                    : (hi ? LSR_ADDR_S2_RES_HI : LSR_ADDR_S2_RES_LO);
      e = hi ? {3'h0, c[12:8]} : c[7:0];
      @(posedge i_ref_clk);
      #1;
      if (sn == 1) s1_sample = '{1'b1, c};
      else s2_sample = '{1'b1, c};
      fork
         begin
            @(posedge i_ref_clk);
            #1;
            s1_sample.valid = 1'b0;
            s2_sample.valid = 1'b0;
         end
         rd(a, e);
      join
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      seed = 32'd58615;
      bad_count = 0;
      n_checks = 0;
      i_arst_n = 1'b0;
      s1_sample = '0;
      s2_sample = '0;
      s1_levels = '0;
      s2_office_trip = 8'h64;
      s2_office_hys = 8'h14;
      s2_dark_trip = 8'h00;
      repeat (20) @(posedge i_ref_clk);
      #1;
      i_arst_n = 1'b1;
      // Reset contents, including the unmapped neighbours
      for (int a = 8'h39; a <= 8'h3F; a++) rd(8'(a), 8'h00);
      // Writes to the read-only result bytes must leave no trace
      h = int'(rnd() & 32'hFF);
      wr(LSR_ADDR_S1_RES_LO, 8'(~h));
      wr(LSR_ADDR_S2_RES_HI, 8'h1F);
      wr(LSR_ADDR_S2_DARK_HYS, 8'(h));
      rd(LSR_ADDR_S2_DARK_HYS, 8'(h));
      rd(LSR_ADDR_S1_RES_LO, 8'h00);
      rd(LSR_ADDR_S2_RES_HI, 8'h00);
      // Sensor 2 dark entry and exit, full-span hysteresis first
      for (int k = 0; k < 2; k++) begin
         h = (k == 0) ? 255 : int'(rnd() & 32'hFF);
         t = 1 + int'(rnd() % 100);
         s2_dark_trip = 8'(t);
         wr(LSR_ADDR_S2_DARK_HYS, 8'(h));
         step(2, t * 4 - 1, 1'b1, 1'b1, 1);
         step(2, t * 4, 1'b1, 1'b1, 0);
         step(2, (t + h) * 4, 1'b1, 1'b1, 0);
         step(2, (t + h) * 4 + 1, 1'b1, 1'b0, 1);
         step(2, 120 * 32, 1'b1, 1'b0, 0);
         step(2, 120 * 32 + 1, 1'b0, 1'b0, 1);
      end
      // Sensor 1 office entry and exit, then full-scale code
      o = 1 + int'(rnd() % 150);
      oh = int'(rnd() % 100);
      s1_levels = '{8'(o), 8'(oh), 8'h00, 8'h00};
      step(1, o * 32, 1'b0, 1'b0, 0);
      step(1, o * 32 - 1, 1'b1, 1'b0, 1);
      step(1, (o + oh) * 32, 1'b1, 1'b0, 0);
      step(1, (o + oh) * 32 + 1, 1'b0, 1'b0, 1);
      step(1, 8191, 1'b0, 1'b0, 0);
      // Codes above every office trip keep both sensors outdoor
      for (int s = 1; s <= 2; s++) begin
         fresh(s, 13'h1300 | 13'(rnd() & 32'hFF), 1'b1);
         fresh(s, 13'h1300 | 13'(rnd() & 32'hFF), 1'b0);
      end
      // Reset in mid-run clears a dark sensor and the hysteresis
      step(2, 0, 1'b1, 1'b1, 1);
      @(posedge i_ref_clk);
      #1;
      i_arst_n = 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1;
      i_arst_n = 1'b1;
      check({6'h00, s2_off, s2_dark}, 8'h00, "flags after reset");
      rd(LSR_ADDR_S2_DARK_HYS, LSR_RST_DARK_HYS);
      rd(LSR_ADDR_S2_RES_LO, 8'h00);
      // Bounded drain of outstanding read notes
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge i_ref_clk);
      if (exp_q.size() > 0) begin
         check(8'(exp_q.size()), 8'h00, "reads never answered");
      end
      conclude();
   end

   // Watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      check(8'h01, 8'h00, "watchdog expired");
      conclude();
   end

endmodule

`default_nettype wire
